// ==== verilog/iqx_consts.vh ====
`ifndef IQX_CONSTS_VH
`define IQX_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define IQX_OFF_ROUTE   8'h00
`define IQX_OFF_CLKCTL  8'h04
`define IQX_OFF_ABCTL   8'h08
`define IQX_OFF_CDCTL   8'h0C
`define IQX_OFF_ABDCI   8'h10
`define IQX_OFF_ABDCQ   8'h14
`define IQX_OFF_CDDCI   8'h18
`define IQX_OFF_CDDCQ   8'h1C
`define IQX_OFF_ABPH    8'h20
`define IQX_OFF_ABAM    8'h24
`define IQX_OFF_CDPH    8'h28
`define IQX_OFF_CDAM    8'h2C
`define IQX_OFF_STAT    8'h30
// ****************************************
// field positions
// ****************************************
`define IQX_PN_EN       27
`define IQX_EXP_LOCK    26
`define IQX_CD_CPLX     25
`define IQX_AB_CPLX     24
`define IQX_INV_LSB     8
`define IQX_DIV_MSB     7
`define IQX_DIV_LSB     6
`define IQX_MUL_MSB     5
`define IQX_MUL_LSB     1
`define IQX_AM_EN       2
`define IQX_PH_EN       1
`define IQX_DC_EN       0
// ****************************************
// reset values and constants
// ****************************************
`define IQX_ROUTE_RST   28'h0000000
`define IQX_CLK_RST     12'h000
`define IQX_CTL_RST     16'h0000
`define IQX_WORD_RST    16'h0000
`define IQX_CORR_RST    14'h0000
`define IQX_PN_SEED     23'h7FFFFF
`define IQX_EXP_FULL    3'h0
`define IQX_MUL_MIN     5'h04
`define IQX_MUL_MAX     5'h14
`define IQX_BW_MAX      4'hB
`define IQX_LOOP_LOG2   5'h0C
`endif

// ==== verilog/iqx_front.v ====
// Contract
// - pn enable runs generator, clear reseeds
// - exponent lock forces 000 on pn
// - cd pairing makes c in-phase, d quadrature
// - ab pairing makes a in-phase, b quadrature
// - pairing only in single-ended cmos mode
// - six channels, complex bit plus select
// - real selects a, b, c, d, pn
// - complex selects ab, cd, pn
// - per-port clock invert picks capture edge
// - pre-pll divider by 1, 2, 4, 8
// - multiplier 4..20 else pll off
// - amplitude decimation two to 12+bw
// - phase decimation two to 12+bw
// - dc decimation two to 12+bw
// - amplitude auto estimate or manual value
// - phase auto estimate or manual value
// - dc auto estimate or manual words
// - real pairs ignore correction enables
// - second control governs cd pair
// - subtract in-phase dc word, 16-bit
// - subtract quadrature dc word, 16-bit
// - i plus phase times q
// - q plus amplitude times q
`timescale 1ns/1ns
`include "iqx_consts.vh"

// ****************************************
// decimation tick counter
// ****************************************
module iqx_decim_tick (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        step,
	input  wire [4:0]  base_log2,
	input  wire [3:0]  bw,
	output wire        tick
);
	reg  [23:0] cnt_ff;   // samples seen this period
	wire [3:0]  bw_c;     // field clamped to its top code
	wire [4:0]  sh;       // log2 of the period
	wire [24:0] lim;      // last count of the period

	assign bw_c = (bw > `IQX_BW_MAX) ? `IQX_BW_MAX : bw;
	assign sh   = base_log2 + {1'b0, bw_c};
	assign lim  = (25'h0000001 << sh) - 25'h0000001;
	assign tick = step & ({1'b0, cnt_ff} == lim);

	// count samples, wrap at end of period
	always @(posedge clk) begin
		if (!rst_b) begin
			cnt_ff <= 24'h000000;
		end else if (tick) begin
			cnt_ff <= 24'h000000;
		end else if (step) begin
			cnt_ff <= cnt_ff + 24'h000001;
		end
	end
endmodule // iqx_decim_tick

// ****************************************
// input crossbar with iq correction
// ****************************************
module iqx_front #(
	parameter [4:0] LOOP_LOG2 = `IQX_LOOP_LOG2
) (
	input  wire        clk,
	input  wire        rst_b,
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        cmos_mode,
	input  wire [3:0]  adc_clk,
	input  wire [63:0] adc_data,
	input  wire [11:0] adc_exp,
	output wire        pll_ref_tick,
	output wire [4:0]  pll_mult,
	output wire        pll_power_down,
	output wire [95:0] ch_i,
	output wire [95:0] ch_q,
	output wire [17:0] ch_exp,
	output wire [5:0]  ch_cplx,
	output wire [5:0]  ch_valid
);
	// ****************************************
	// register file
	// ****************************************
	reg  [27:0] route_ff;           // routing control
	reg  [11:0] clkctl_ff;          // clock and pll control
	reg  [15:0] ctl_ff [0:1];       // correction control per pair
	reg  [15:0] dci_ff [0:1];       // manual in-phase dc words
	reg  [15:0] dcq_ff [0:1];       // manual quadrature dc words
	reg  [13:0] phm_ff [0:1];       // manual phase values
	reg  [13:0] amm_ff [0:1];       // manual amplitude values
	reg  [31:0] nxt_rdata;          // read mux
	wire [1:0]  pair_cplx;          // effective pairing per pair

	// writes; one word per aligned offset
	always @(posedge clk) begin
		if (!rst_b) begin
			route_ff  <= `IQX_ROUTE_RST;
			clkctl_ff <= `IQX_CLK_RST;
			ctl_ff[0] <= `IQX_CTL_RST;
			ctl_ff[1] <= `IQX_CTL_RST;
			dci_ff[0] <= `IQX_WORD_RST;
			dci_ff[1] <= `IQX_WORD_RST;
			dcq_ff[0] <= `IQX_WORD_RST;
			dcq_ff[1] <= `IQX_WORD_RST;
			phm_ff[0] <= `IQX_CORR_RST;
			phm_ff[1] <= `IQX_CORR_RST;
			amm_ff[0] <= `IQX_CORR_RST;
			amm_ff[1] <= `IQX_CORR_RST;
		end else if (reg_wr) begin
			if (reg_addr == `IQX_OFF_ROUTE) begin
				route_ff <= reg_wdata[27:0];
			end else if (reg_addr == `IQX_OFF_CLKCTL) begin
				clkctl_ff <= reg_wdata[11:0];
			end else if (reg_addr == `IQX_OFF_ABCTL) begin
				ctl_ff[0] <= reg_wdata[15:0];
			end else if (reg_addr == `IQX_OFF_CDCTL) begin
				ctl_ff[1] <= reg_wdata[15:0];
			end else if (reg_addr == `IQX_OFF_ABDCI) begin
				dci_ff[0] <= reg_wdata[15:0];
			end else if (reg_addr == `IQX_OFF_ABDCQ) begin
				dcq_ff[0] <= reg_wdata[15:0];
			end else if (reg_addr == `IQX_OFF_CDDCI) begin
				dci_ff[1] <= reg_wdata[15:0];
			end else if (reg_addr == `IQX_OFF_CDDCQ) begin
				dcq_ff[1] <= reg_wdata[15:0];
			end else if (reg_addr == `IQX_OFF_ABPH) begin
				phm_ff[0] <= reg_wdata[13:0];
			end else if (reg_addr == `IQX_OFF_ABAM) begin
				amm_ff[0] <= reg_wdata[13:0];
			end else if (reg_addr == `IQX_OFF_CDPH) begin
				phm_ff[1] <= reg_wdata[13:0];
			end else if (reg_addr == `IQX_OFF_CDAM) begin
				amm_ff[1] <= reg_wdata[13:0];
			end
		end
	end

	// read mux; unmapped reads as zero
	always @* begin
		nxt_rdata = 32'h00000000;
		if (reg_addr == `IQX_OFF_ROUTE) begin
			nxt_rdata = {4'h0, route_ff};
		end else if (reg_addr == `IQX_OFF_CLKCTL) begin
			nxt_rdata = {20'h00000, clkctl_ff};
		end else if (reg_addr == `IQX_OFF_ABCTL) begin
			nxt_rdata = {16'h0000, ctl_ff[0]};
		end else if (reg_addr == `IQX_OFF_CDCTL) begin
			nxt_rdata = {16'h0000, ctl_ff[1]};
		end else if (reg_addr == `IQX_OFF_ABDCI) begin
			nxt_rdata = {16'h0000, dci_ff[0]};
		end else if (reg_addr == `IQX_OFF_ABDCQ) begin
			nxt_rdata = {16'h0000, dcq_ff[0]};
		end else if (reg_addr == `IQX_OFF_CDDCI) begin
			nxt_rdata = {16'h0000, dci_ff[1]};
		end else if (reg_addr == `IQX_OFF_CDDCQ) begin
			nxt_rdata = {16'h0000, dcq_ff[1]};
		end else if (reg_addr == `IQX_OFF_ABPH) begin
			nxt_rdata = {18'h00000, phm_ff[0]};
		end else if (reg_addr == `IQX_OFF_ABAM) begin
			nxt_rdata = {18'h00000, amm_ff[0]};
		end else if (reg_addr == `IQX_OFF_CDPH) begin
			nxt_rdata = {18'h00000, phm_ff[1]};
		end else if (reg_addr == `IQX_OFF_CDAM) begin
			nxt_rdata = {18'h00000, amm_ff[1]};
		end else if (reg_addr == `IQX_OFF_STAT) begin
			nxt_rdata = {29'h00000000, pair_cplx, pll_power_down};
		end
	end

	// read data stands one cycle after the strobe
	always @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ****************************************
	// pseudorandom source
	// ****************************************
	reg  [22:0] pn_ff;              // generator state
	wire        pn_on;              // generator running
	wire [2:0]  pn_exp;             // exponent on pn samples

	assign pn_on  = route_ff[`IQX_PN_EN];
	assign pn_exp = route_ff[`IQX_EXP_LOCK] ? `IQX_EXP_FULL : pn_ff[18:16];

	// step while enabled, reseed while disabled
	always @(posedge clk) begin
		if (!rst_b) begin
			pn_ff <= `IQX_PN_SEED;
		end else if (pn_on) begin
			pn_ff <= {pn_ff[21:0], pn_ff[22] ^ pn_ff[17]};
		end else begin
			pn_ff <= `IQX_PN_SEED;
		end
	end

	// ****************************************
	// port capture
	// ****************************************
	reg  [3:0]  pclk_ff;            // previous port clock levels
	reg  [3:0]  cap_v_ff;           // sample captured this cycle
	reg  [15:0] smp_ff [0:3];       // captured port samples
	reg  [2:0]  exp_ff [0:3];       // captured port exponents
	wire [3:0]  inv;                // clock invert per port
	wire [3:0]  cap_edge;           // chosen edge seen
	integer     k;

	assign inv      = clkctl_ff[`IQX_INV_LSB+3:`IQX_INV_LSB];
	assign cap_edge = (inv & pclk_ff & ~adc_clk) | (~inv & ~pclk_ff & adc_clk);

	// capture each port on its selected clock edge
	always @(posedge clk) begin
		if (!rst_b) begin
			pclk_ff  <= 4'h0;
			cap_v_ff <= 4'h0;
			for (k = 0; k < 4; k = k + 1) begin
				smp_ff[k] <= 16'h0000;
				exp_ff[k] <= 3'h0;
			end
		end else begin
			pclk_ff  <= adc_clk;
			cap_v_ff <= cap_edge;
			for (k = 0; k < 4; k = k + 1) begin
				if (cap_edge[k]) begin
					smp_ff[k] <= adc_data[16*k +: 16];
					exp_ff[k] <= adc_exp[3*k +: 3];
				end
			end
		end
	end

	// ****************************************
	// pre-pll divider and multiplier
	// ****************************************
	reg  [2:0]  div_ff;             // port a rising edge count
	reg  [2:0]  div_lim;            // last count for divide code
	wire        a_rise;             // raw port a clock rising

	assign a_rise         = ~pclk_ff[0] & adc_clk[0];
	assign pll_mult       = clkctl_ff[`IQX_MUL_MSB:`IQX_MUL_LSB];
	assign pll_power_down = (pll_mult < `IQX_MUL_MIN) | (pll_mult > `IQX_MUL_MAX);
	// powered down: every raw port a rising edge passes straight through
	assign pll_ref_tick   = a_rise & (pll_power_down | (div_ff == div_lim));

	// divide code to last count
	always @* begin
		case (clkctl_ff[`IQX_DIV_MSB:`IQX_DIV_LSB])
			2'h0:    div_lim = 3'h0;
			2'h1:    div_lim = 3'h1;
			2'h2:    div_lim = 3'h3;
			default: div_lim = 3'h7;
		endcase
	end

	// count port a edges toward the divided tick
	always @(posedge clk) begin
		if (!rst_b) begin
			div_ff <= 3'h0;
		end else if (a_rise) begin
			div_ff <= (div_ff >= div_lim) ? 3'h0 : div_ff + 3'h1;
		end
	end

	// ****************************************
	// iq correction per pair
	// ****************************************
	wire [31:0] pr_i;               // corrected in-phase per pair
	wire [31:0] pr_q;               // corrected quadrature per pair
	wire [1:0]  pr_v;               // pair sample valid

	assign pair_cplx = route_ff[`IQX_CD_CPLX:`IQX_AB_CPLX] & {2{cmos_mode}};

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_pair
			reg  signed [39:0] dca_i_ff;   // in-phase dc accumulator
			reg  signed [39:0] dca_q_ff;   // quadrature dc accumulator
			reg  signed [24:0] pha_ff;     // phase error sign count
			reg  signed [24:0] ama_ff;     // amplitude error sign count
			reg         [15:0] dce_i_ff;   // estimated in-phase dc
			reg         [15:0] dce_q_ff;   // estimated quadrature dc
			reg         [13:0] phe_ff;     // estimated phase value
			reg         [13:0] ame_ff;     // estimated amplitude value
			reg         [15:0] oi_ff;      // output in-phase
			reg         [15:0] oq_ff;      // output quadrature
			reg                ov_ff;      // output valid
			wire        [15:0] ri;
			wire        [15:0] rq;
			wire        [15:0] dcv_i;
			wire        [15:0] dcv_q;
			wire        [13:0] phv;
			wire        [13:0] amv;
			wire signed [15:0] i1;
			wire signed [15:0] q1;
			wire signed [29:0] pph;
			wire signed [29:0] pam;
			wire        [15:0] i2;
			wire        [15:0] q2;
			wire               step;
			wire               t_am;
			wire               t_ph;
			wire               t_dc;
			wire [4:0]         dsh;
			wire [15:0]        ai;
			wire [15:0]        aq;
			wire signed [39:0] dsum_i;     // in-phase sum including this sample
			wire signed [39:0] dsum_q;     // quadrature sum including this sample
			wire signed [39:0] dmean_i;    // in-phase block mean
			wire signed [39:0] dmean_q;    // quadrature block mean

			assign ri    = smp_ff[2*p];
			assign rq    = smp_ff[2*p+1];
			assign step  = cap_v_ff[2*p] & pair_cplx[p];
			// enable picks estimate or manual value
			assign dcv_i = ctl_ff[p][`IQX_DC_EN] ? dce_i_ff : dci_ff[p];
			assign dcv_q = ctl_ff[p][`IQX_DC_EN] ? dce_q_ff : dcq_ff[p];
			assign phv   = ctl_ff[p][`IQX_PH_EN] ? phe_ff : phm_ff[p];
			assign amv   = ctl_ff[p][`IQX_AM_EN] ? ame_ff : amm_ff[p];
			assign i1    = ri - dcv_i;
			assign q1    = rq - dcv_q;
			assign pph   = $signed(phv) * q1;
			assign pam   = $signed(amv) * q1;
			assign i2    = i1 + pph[28:13];
			assign q2    = q1 + pam[28:13];
			assign ai    = i1[15] ? -i1 : i1;
			assign aq    = q1[15] ? -q1 : q1;
			assign dsh   = LOOP_LOG2 + {1'b0, (ctl_ff[p][7:4] > `IQX_BW_MAX) ?
				`IQX_BW_MAX : ctl_ff[p][7:4]};
			// the closing sample belongs to the period, so the mean spans the full count
			assign dsum_i  = dca_i_ff + $signed({{24{ri[15]}}, ri});
			assign dsum_q  = dca_q_ff + $signed({{24{rq[15]}}, rq});
			assign dmean_i = dsum_i >>> dsh;
			assign dmean_q = dsum_q >>> dsh;

			iqx_decim_tick u_am (
				.clk       (clk),
				.rst_b     (rst_b),
				.step      (step),
				.base_log2 (LOOP_LOG2),
				.bw        (ctl_ff[p][15:12]),
				.tick      (t_am)
			);
			iqx_decim_tick u_ph (
				.clk       (clk),
				.rst_b     (rst_b),
				.step      (step),
				.base_log2 (LOOP_LOG2),
				.bw        (ctl_ff[p][11:8]),
				.tick      (t_ph)
			);
			iqx_decim_tick u_dc (
				.clk       (clk),
				.rst_b     (rst_b),
				.step      (step),
				.base_log2 (LOOP_LOG2),
				.bw        (ctl_ff[p][7:4]),
				.tick      (t_dc)
			);

			// estimators: dc is a block mean, others sign-steered
			always @(posedge clk) begin
				if (!rst_b) begin
					dca_i_ff <= 40'h0000000000;
					dca_q_ff <= 40'h0000000000;
					pha_ff   <= 25'h0000000;
					ama_ff   <= 25'h0000000;
					dce_i_ff <= 16'h0000;
					dce_q_ff <= 16'h0000;
					phe_ff   <= 14'h0000;
					ame_ff   <= 14'h0000;
				end else if (step) begin
					dca_i_ff <= t_dc ? 40'h0000000000 : dsum_i;
					dca_q_ff <= t_dc ? 40'h0000000000 : dsum_q;
					// mean fits the sample width; upper bits are sign only
					if (t_dc) begin
						dce_i_ff <= dmean_i[15:0];
						dce_q_ff <= dmean_q[15:0];
					end
					// positive count: i and q correlate, lower phase
					pha_ff <= t_ph ? 25'h0000000 :
						pha_ff + ((i1[15] ^ q1[15]) ? -25'sd1 : 25'sd1);
					if (t_ph) begin
						phe_ff <= (pha_ff > 0) ? phe_ff - 14'h0001 : phe_ff + 14'h0001;
					end
					// positive count: q larger than i, lower gain
					ama_ff <= t_am ? 25'h0000000 :
						ama_ff + ((aq > ai) ? 25'sd1 : -25'sd1);
					if (t_am) begin
						ame_ff <= (ama_ff > 0) ? ame_ff - 14'h0001 : ame_ff + 14'h0001;
					end
				end
			end

			// pair output; real pairs bypass correction
			always @(posedge clk) begin
				if (!rst_b) begin
					oi_ff <= 16'h0000;
					oq_ff <= 16'h0000;
					ov_ff <= 1'b0;
				end else begin
					ov_ff <= cap_v_ff[2*p];
					if (cap_v_ff[2*p]) begin
						oi_ff <= pair_cplx[p] ? i2 : ri;
						oq_ff <= pair_cplx[p] ? q2 : 16'h0000;
					end
				end
			end

			assign pr_i[16*p +: 16] = oi_ff;
			assign pr_q[16*p +: 16] = oq_ff;
			assign pr_v[p]          = ov_ff;
		end
	endgenerate

	// ****************************************
	// channel crossbar
	// ****************************************
	genvar c;
	generate
		for (c = 0; c < 6; c = c + 1) begin : g_ch
			reg  [15:0] xi_ff;   // channel in-phase
			reg  [15:0] xq_ff;   // channel quadrature
			reg  [2:0]  xe_ff;   // channel exponent
			reg         xc_ff;   // channel complex flag
			reg         xv_ff;   // channel valid
			wire        cx;
			wire [2:0]  sel;

			assign cx  = route_ff[4*c+3];
			assign sel = route_ff[4*c +: 3];

			// route the selected source; unlisted codes give zero
			always @(posedge clk) begin
				if (!rst_b) begin
					xi_ff <= 16'h0000;
					xq_ff <= 16'h0000;
					xe_ff <= 3'h0;
					xc_ff <= 1'b0;
					xv_ff <= 1'b0;
				end else begin
					xc_ff <= cx;
					xi_ff <= 16'h0000;
					xq_ff <= 16'h0000;
					xe_ff <= 3'h0;
					xv_ff <= 1'b0;
					if (!cx) begin
						if (sel == 3'h4) begin
							xi_ff <= pn_ff[15:0];
							xe_ff <= pn_exp;
							xv_ff <= pn_on;
						end else if (sel[2] == 1'b0) begin
							xi_ff <= smp_ff[sel[1:0]];
							xe_ff <= exp_ff[sel[1:0]];
							xv_ff <= cap_v_ff[sel[1:0]];
						end
					end else begin
						if (sel == 3'h0 || sel == 3'h1) begin
							xi_ff <= pr_i[16*sel[0] +: 16];
							xq_ff <= pr_q[16*sel[0] +: 16];
							xe_ff <= exp_ff[{sel[0], 1'b0}];
							xv_ff <= pr_v[sel[0]];
						end else if (sel == 3'h2) begin
							xi_ff <= pn_ff[15:0];
							xq_ff <= pn_ff[22:7];
							xe_ff <= pn_exp;
							xv_ff <= pn_on;
						end
					end
				end
			end

			assign ch_i[16*c +: 16] = xi_ff;
			assign ch_q[16*c +: 16] = xq_ff;
			assign ch_exp[3*c +: 3] = xe_ff;
			assign ch_cplx[c]       = xc_ff;
			assign ch_valid[c]      = xv_ff;
		end
	endgenerate
endmodule // iqx_front

// ==== testbench/iqx_adc_model.sv ====
`timescale 1ns/1ns
// ****************************************
// four adc ports, all four clocks driven with one shared waveform
// ****************************************
module iqx_adc_model (
	input  wire        clk,
	input  wire        run,
	input  wire [63:0] smp,
	output reg  [3:0]  adc_clk,
	output reg  [63:0] adc_data,
	output reg  [11:0] adc_exp
);
	reg [1:0] ph_ff; // phase inside one port clock period
	initial begin
		adc_clk = 4'h0;
		adc_data = 64'h0;
		adc_exp = 12'h0;
		ph_ff = 2'h0;
	end
	// clock high two cycles, low two; data moves mid-low, away from both edges
	always @(posedge clk) begin
		if (run) begin
			ph_ff <= ph_ff + 2'h1;
			adc_clk <= {4{ph_ff == 2'h1 || ph_ff == 2'h2}};
			adc_data <= (ph_ff == 2'h0) ? smp : adc_data;
			adc_exp <= 12'hAD1; // exponents d=5 c=3 b=2 a=1
		end else begin
			// clock stands still, released data toggles every cycle
			adc_clk <= 4'h0;
			adc_data <= ~adc_data;
			adc_exp <= ~adc_exp;
		end
	end
endmodule // iqx_adc_model

// ==== testbench/iqx_front_assertions.sv ====
`timescale 1ns/1ns
`include "iqx_consts.vh"
// ****************************************
// port checker for the input front end
// ****************************************
module iqx_front_assertions #(
	parameter [4:0] LOOP_LOG2 = 5'h0C
) (
	input wire        clk,
	input wire        rst_b,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire [3:0]  adc_clk,
	input wire [63:0] adc_data,
	input wire        pll_ref_tick,
	input wire [4:0]  pll_mult,
	input wire        pll_power_down,
	input wire [95:0] ch_i,
	input wire [17:0] ch_exp,
	input wire [5:0]  ch_valid
);
	reg  [27:0] route_ff; // shadow of routing register
	reg  [11:0] clkc_ff;  // shadow of clock register
	wire        port_a_real; // channel 0 reads port a as real input
	wire        pn_lock_ch0; // channel 0 on locked pseudorandom source
	wire        pn_off_ch0;  // channel 0 on stopped pseudorandom source
	// shadows follow register writes
	always @(posedge clk) begin
		if (!rst_b) begin
			route_ff <= 28'h0000000;
			clkc_ff <= 12'h000;
		end else if (reg_wr && reg_addr == `IQX_OFF_ROUTE) begin
			route_ff <= reg_wdata[27:0];
		end else if (reg_wr && reg_addr == `IQX_OFF_CLKCTL) begin
			clkc_ff <= reg_wdata[11:0];
		end
	end
	assign port_a_real = route_ff[3:0] == 4'h0 && !route_ff[24];
	assign pn_lock_ch0 = route_ff[27:26] == 2'h3 && route_ff[3:0] == 4'h4;
	assign pn_off_ch0 = !route_ff[27] && route_ff[3:0] == 4'h4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// capture edge of port a, plain or inverted clock
	sequence s_rise_a;
		$rose(adc_clk[0]) && port_a_real && !clkc_ff[8] && $stable(clkc_ff[8]);
	endsequence
	sequence s_fall_a;
		$fell(adc_clk[0]) && port_a_real && clkc_ff[8] && $stable(clkc_ff[8]);
	endsequence
	sequence s_a_out;
		ch_valid[0] && ch_i[15:0] == $past(adc_data[15:0], 2);
	endsequence
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	a_pll_off_range: assert property (pll_power_down == (pll_mult < 5'h04 || pll_mult > 5'h14))
		else $error("pll power down disagrees with multiplier");
	a_mult_follows_write: assert property (reg_wr && reg_addr == `IQX_OFF_CLKCTL |=> pll_mult == $past(reg_wdata[5:1]))
		else $error("multiplier output not taken from write");
	a_rise_capture_a: assert property (s_rise_a ##2 port_a_real && !clkc_ff[8] |-> s_a_out)
		else $error("port a rising capture not on channel 0");
	a_fall_capture_a: assert property (s_fall_a ##2 port_a_real && clkc_ff[8] |-> s_a_out)
		else $error("port a inverted capture not on channel 0");
	a_exp_lock_zero: assert property ((pn_lock_ch0 [*4]) ##0 ch_valid[0] |-> ch_exp[2:0] == 3'h0)
		else $error("locked exponent not zero");
	a_pn_stopped: assert property ((pn_off_ch0 [*4]) |-> !ch_valid[0])
		else $error("stopped generator still gives samples");
	a_tick_single: assert property (pll_ref_tick |-> adc_clk[0] ##1 !pll_ref_tick)
		else $error("reference tick not a single pulse on port a high");
endmodule // iqx_front_assertions

bind iqx_front iqx_front_assertions #(.LOOP_LOG2(LOOP_LOG2)) u_iqx_front_assertions (.clk, .rst_b,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_clk, .adc_data, .pll_ref_tick,
	.pll_mult, .pll_power_down, .ch_i, .ch_exp, .ch_valid);

// ==== testbench/iqx_front_tb.sv ====
`timescale 1ns/1ns
`include "iqx_consts.vh"
module iqx_front_tb;
	reg         clk;
	reg         rst_b;
	reg  [7:0]  reg_addr;
	reg  [31:0] reg_wdata;
	reg         reg_wr;
	reg         reg_rd;
	wire [31:0] reg_rdata;
	reg         cmos_mode;
	reg         run;      // adc model running
	wire [3:0]  adc_clk;
	wire [63:0] adc_data;
	wire [11:0] adc_exp;
	wire        pll_ref_tick;
	wire [4:0]  pll_mult;
	wire        pll_power_down;
	wire [95:0] ch_i;
	wire [95:0] ch_q;
	wire [17:0] ch_exp;
	wire [5:0]  ch_cplx;
	wire [5:0]  ch_valid;
	int         miscompares;
	int         compares;
	localparam [63:0] SMP = 64'h0200080004001234; // port samples d c b a
	// ****************************************
	// design and adc model
	// ****************************************
	iqx_front #(.LOOP_LOG2(5'h02)) u_iqx_front (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .cmos_mode, .adc_clk, .adc_data, .adc_exp, .pll_ref_tick, .pll_mult,
		.pll_power_down, .ch_i, .ch_q, .ch_exp, .ch_cplx, .ch_valid);
	iqx_adc_model u_iqx_adc_model (.clk, .run, .smp(SMP), .adc_clk, .adc_data, .adc_exp);
	always #20 clk = ~clk;
	// ****************************************
	// shared tasks
	// ****************************************
	task wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rchk(input string name, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(name, reg_rdata, e);
	endtask
	// wait for the next sample pulse of a channel, bounded
	task wait_v(input int c);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (ch_valid[c] !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 60) begin
			chk("sample timeout", 0, 1);
			wrap_up;
		end
	endtask
	task cx(input int c, input logic [15:0] ei, input logic [15:0] eq);
		repeat (3) wait_v(c);
		chk("complex i", ch_i[16*c +: 16], ei);
		chk("complex q", ch_q[16*c +: 16], eq);
		chk("complex flag", ch_cplx[c], 1);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_regs;
		logic [7:0]  off [0:4] = '{8'h04, 8'h08, 8'h20, 8'h10, 8'h00};
		logic [31:0] wv [0:4] = '{32'hFFFFFFFE, 32'hFFFFFFF7, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
		logic [31:0] ev [0:4] = '{32'hFFE, 32'hFFF7, 32'h3FFF, 32'hFFFF, 32'hFFFFFFF};
		for (int i = 0; i < 13; i++)
			rchk("reset value", 8'(i * 4), (i == 12) ? 32'h1 : 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rchk("unmapped", 8'h40, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(off[i], wv[i]);
			rchk("width", off[i], ev[i]);
			wr(off[i], 32'h0);
		end
	endtask
	task t_pll;
		logic [4:0] m [0:3] = '{5'h03, 5'h04, 5'h14, 5'h15};
		int t;
		for (int i = 0; i < 4; i++) begin
			wr(`IQX_OFF_CLKCTL, {26'h0, m[i], 1'b0});
			#1 chk("pll off", pll_power_down, (i == 0 || i == 3));
			chk("pll mult", pll_mult, m[i]);
		end
		run <= 1'b1;
		for (int d = 0; d < 4; d++) begin
			wr(`IQX_OFF_CLKCTL, {24'h0, 2'(d), 5'h05, 1'b0});
			repeat (8) @(posedge clk);
			t = 0;
			repeat (128) begin
				@(posedge clk);
				#1 t += pll_ref_tick;
			end
			chk("divided ticks", t, 32 >> d);
		end
	endtask
	task t_real(input logic [11:0] inv);
		int p [0:5] = '{0, 1, 2, 3, 0, 3};
		wr(`IQX_OFF_CLKCTL, {20'h0, inv});
		wr(`IQX_OFF_ABDCI, 32'h34);
		wr(`IQX_OFF_ABCTL, 32'h7);
		wr(`IQX_OFF_ROUTE, 32'h00303210);
		for (int c = 0; c < 6; c++) begin
			repeat (2) wait_v(c);
			chk("real data", ch_i[16*c +: 16], SMP[16*p[c] +: 16]);
			chk("real exp", ch_exp[3*c +: 3], 12'hAD1 >> (3 * p[c]) & 12'h7);
			chk("real flag", ch_cplx[c], 0);
		end
	endtask
	task t_pair;
		wr(`IQX_OFF_CLKCTL, 32'h0);
		wr(`IQX_OFF_ABCTL, 32'h0);
		cmos_mode <= 1'b0;
		wr(`IQX_OFF_ROUTE, 32'h03000098);
		rchk("pair status", `IQX_OFF_STAT, 32'h1);
		cmos_mode <= 1'b1;
		rchk("pair status", `IQX_OFF_STAT, 32'h7);
		wr(`IQX_OFF_ABDCQ, 32'h100);
		wr(`IQX_OFF_CDDCI, 32'h100);
		cx(0, 16'h1200, 16'h0300);
		cx(1, 16'h0700, 16'h0200);
		wr(`IQX_OFF_ABDCI, 32'h0);
		wr(`IQX_OFF_ABDCQ, 32'h0);
		wr(`IQX_OFF_ABPH, 32'h1000);
		cx(0, 16'h1434, 16'h0400);
		wr(`IQX_OFF_ABPH, 32'h0);
		wr(`IQX_OFF_ABAM, 32'h1000);
		cx(0, 16'h1234, 16'h0600);
		wr(`IQX_OFF_ABAM, 32'h0);
		wr(`IQX_OFF_ABCTL, 32'h1);
		wr(`IQX_OFF_CDCTL, 32'h1);
		repeat (400) @(posedge clk);
		cx(0, 16'h0, 16'h0);
		cx(1, 16'h0, 16'h0);
		chk("pair exp", ch_exp[2:0], 3'h1);
	endtask
	task t_pn;
		logic [15:0] v1;
		wr(`IQX_OFF_ROUTE, 32'h0C000004);
		wait_v(0);
		v1 = ch_i[15:0];
		chk("locked exp", ch_exp[2:0], 3'h0);
		wait_v(0);
		chk("pn moves", ch_i[15:0] != v1, 1);
		wr(`IQX_OFF_ROUTE, 32'h00000004);
		repeat (8) begin
			@(posedge clk);
			#1 chk("pn stopped", ch_valid[0], 0);
		end
		wr(`IQX_OFF_ROUTE, 32'h0C000004);
		wait_v(0);
		chk("pn reseed", ch_i[15:0], v1);
		wr(`IQX_OFF_ROUTE, 32'h0800000A);
		wait_v(0);
		chk("pn complex", ch_cplx[0], 1);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cmos_mode = 1'b1;
		run = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_pll;
		t_real(12'h000);
		t_real(12'hF00);
		t_pair;
		t_pn;
		wrap_up;
	end
endmodule // iqx_front_tb
